// >>> core/ibx_pkg.sv
// constants for the increment / or / jump execution slice
// assumes a 14-bit instruction word, 8-bit data and a 13-bit program counter
package ibx_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 13;
    localparam int JUMP_LIT_W = 11;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TARGET_BIT = 7;
    localparam int LATCH_LO_BIT = 3;
    localparam int LATCH_HI_BIT = 4;

    // ------------------------------------------------------------
    // opcode patterns and masks
    // ------------------------------------------------------------
    localparam logic [13:0] OPC_MASK_BYTE = 14'h3f00;
    localparam logic [13:0] OPC_MASK_JUMP = 14'h3800;
    localparam logic [13:0] OPC_INC_SKIP = 14'h0f00;
    localparam logic [13:0] OPC_INC_FILE = 14'h0a00;
    localparam logic [13:0] OPC_OR_FILE = 14'h0400;
    localparam logic [13:0] OPC_OR_LIT = 14'h3800;
    localparam logic [13:0] OPC_JUMP = 14'h2800;

    // ------------------------------------------------------------
    // reset values and steps
    // ------------------------------------------------------------
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [12:0] PC_STEP = 13'h0001;
    localparam logic [12:0] PC_SKIP_STEP = 13'h0002;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] DATA_ONE = 8'h01;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IBX_ST_EXEC = 2'b01,
        IBX_ST_IDLE = 2'b10
    } ibx_state_e;

endpackage : ibx_pkg

// >>> core/ibx_exec.sv
// execution slice for increment, increment-skip, or-literal, or-file and jump
// assumes file_rdata_i holds the register addressed by instr_word_i[6:0] in the same cycle
//
// Behaviour
// - increment_skip_zero adds one to the file register, sends it to accumulator (target 0) or register (1), no flag changes.
// - a nonzero increment_skip_zero result lets the next instruction run, a zero result runs an idle_op in its place.
// - unconditional_jump_op takes an 11-bit literal 0 to 2047 and always transfers control.
// - the jump loads the literal into program_counter 10:0 and upper_address_latch 4:3 into program_counter 12:11.
// - the jump takes two cycles and leaves every status flag unchanged.
// - or_literal_op ors the accumulator with an 8-bit literal, writes the accumulator and updates the zero flag.
// - increment_file_op adds one to the file register, routes by target_select and updates the zero flag.
// - or_file_op ors the accumulator with the file register, routes by target_select and updates the zero flag.
`timescale 1ns/10ps
module ibx_exec (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_word_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic [7:0] upper_address_latch_i,
    output logic [6:0] file_addr_o,
    output logic file_we_o,
    output logic [7:0] file_wdata_o,
    output logic [7:0] accum_o,
    output logic zero_flag_o,
    output logic [12:0] program_counter_o,
    output logic idle_slot_o
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic op_match(input logic [13:0] word, input logic [13:0] mask, input logic [13:0] pat);
        op_match = (word & mask) == pat;
    endfunction : op_match

    function automatic logic is_zero(input logic [7:0] value);
        is_zero = value == ibx_pkg::DATA_ZERO;
    endfunction : is_zero

    ibx_pkg::ibx_state_e state_q;
    ibx_pkg::ibx_state_e state_d;
    logic take;
    logic is_inc_skip;
    logic is_inc_file;
    logic is_or_file;
    logic is_or_lit;
    logic is_jump;
    logic to_file;
    logic [7:0] result;
    logic wr_file;
    logic wr_acc;
    logic upd_zero;
    logic do_skip;
    logic [12:0] jump_target;
    logic [12:0] pc_d;
    logic [7:0] acc_q;
    logic zero_q;
    logic [12:0] pc_q;
    logic [6:0] addr_q;
    logic we_q;
    logic [7:0] wdata_q;
    logic idle_q;

    assign take = instr_valid_i && (state_q == ibx_pkg::IBX_ST_EXEC);
    assign is_inc_skip = op_match(instr_word_i, ibx_pkg::OPC_MASK_BYTE, ibx_pkg::OPC_INC_SKIP);
    assign is_inc_file = op_match(instr_word_i, ibx_pkg::OPC_MASK_BYTE, ibx_pkg::OPC_INC_FILE);
    assign is_or_file = op_match(instr_word_i, ibx_pkg::OPC_MASK_BYTE, ibx_pkg::OPC_OR_FILE);
    assign is_or_lit = op_match(instr_word_i, ibx_pkg::OPC_MASK_BYTE, ibx_pkg::OPC_OR_LIT);
    assign is_jump = op_match(instr_word_i, ibx_pkg::OPC_MASK_JUMP, ibx_pkg::OPC_JUMP);
    assign to_file = instr_word_i[ibx_pkg::TARGET_BIT];
    assign jump_target = {upper_address_latch_i[ibx_pkg::LATCH_HI_BIT:ibx_pkg::LATCH_LO_BIT],
                          instr_word_i[ibx_pkg::JUMP_LIT_W-1:0]};

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    always_comb begin
        result = ibx_pkg::DATA_ZERO;
        wr_file = 1'b0;
        wr_acc = 1'b0;
        upd_zero = 1'b0;
        do_skip = 1'b0;
        if (take) begin
            if (is_inc_skip) begin
                result = file_rdata_i + ibx_pkg::DATA_ONE;
                wr_file = to_file;
                wr_acc = !to_file;
                do_skip = is_zero(result);
            end else if (is_inc_file) begin
                result = file_rdata_i + ibx_pkg::DATA_ONE;
                wr_file = to_file;
                wr_acc = !to_file;
                upd_zero = 1'b1;
            end else if (is_or_file) begin
                result = acc_q | file_rdata_i;
                wr_file = to_file;
                wr_acc = !to_file;
                upd_zero = 1'b1;
            end else if (is_or_lit) begin
                result = acc_q | instr_word_i[ibx_pkg::DATA_W-1:0];
                wr_acc = 1'b1;
                upd_zero = 1'b1;
            end
        end
    end

    always_comb begin
        pc_d = pc_q;
        if (take) begin
            if (is_jump) begin
                pc_d = jump_target;
            end else if (do_skip) begin
                pc_d = pc_q + ibx_pkg::PC_SKIP_STEP;
            end else begin
                pc_d = pc_q + ibx_pkg::PC_STEP;
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer: second cycle of jump or taken skip is an idle slot
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ibx_pkg::IBX_ST_EXEC: begin
                if (take && (is_jump || do_skip)) begin
                    state_d = ibx_pkg::IBX_ST_IDLE;
                end
            end
            ibx_pkg::IBX_ST_IDLE: begin
                state_d = ibx_pkg::IBX_ST_EXEC;
            end
            default: begin
                state_d = ibx_pkg::IBX_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_q <= ibx_pkg::IBX_ST_EXEC;
            idle_q <= 1'b0;
        end else begin
            state_q <= state_d;
            idle_q <= state_d == ibx_pkg::IBX_ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pc_q <= ibx_pkg::PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    // ------------------------------------------------------------
    // accumulator and zero flag
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            acc_q <= ibx_pkg::ACC_RESET;
        end else if (wr_acc) begin
            acc_q <= result;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            zero_q <= 1'b0;
        end else if (upd_zero) begin
            zero_q <= is_zero(result);
        end
    end

    // ------------------------------------------------------------
    // file register write port
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            addr_q <= 7'h00;
            we_q <= 1'b0;
            wdata_q <= ibx_pkg::DATA_ZERO;
        end else begin
            we_q <= wr_file;
            wdata_q <= result;
            if (take) begin
                addr_q <= instr_word_i[ibx_pkg::ADDR_W-1:0];
            end
        end
    end

    assign file_addr_o = addr_q;
    assign file_we_o = we_q;
    assign file_wdata_o = wdata_q;
    assign accum_o = acc_q;
    assign zero_flag_o = zero_q;
    assign program_counter_o = pc_q;
    assign idle_slot_o = idle_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence inc_skip_taken;
        take && is_inc_skip;
    endsequence

    sequence jump_taken;
        take && is_jump;
    endsequence

    inc_skip_route_a: assert property (
        inc_skip_taken and (to_file && !is_zero(file_rdata_i + ibx_pkg::DATA_ONE))
        |=> file_we_o && file_wdata_o == 8'($past(file_rdata_i) + 8'h01) && $stable(zero_flag_o))
        else $error("increment-skip result not written to file");

    skip_idle_slot_a: assert property (
        inc_skip_taken and (file_rdata_i == 8'hff)
        |=> idle_slot_o ##1 !idle_slot_o)
        else $error("zero skip result did not idle exactly one slot");

    no_skip_run_a: assert property (
        inc_skip_taken and (file_rdata_i != 8'hff)
        |=> !idle_slot_o)
        else $error("nonzero skip result idled");

    jump_target_a: assert property (
        jump_taken
        |=> program_counter_o == {$past(upper_address_latch_i[4:3]), $past(instr_word_i[10:0])})
        else $error("jump target wrong");

    jump_two_cycle_a: assert property (
        jump_taken
        |=> idle_slot_o && $stable(zero_flag_o) && $stable(accum_o) ##1 !idle_slot_o && $stable(zero_flag_o))
        else $error("jump not two cycles or flag changed");

    or_literal_acc_a: assert property (
        take && is_or_lit
        |=> accum_o == ($past(accum_o) | $past(instr_word_i[7:0])) && !file_we_o)
        else $error("or literal result wrong");

    inc_file_acc_a: assert property (
        take && is_inc_file && !to_file
        |=> accum_o == 8'($past(file_rdata_i) + 8'h01) && !file_we_o)
        else $error("increment to accumulator wrong");

    or_file_reg_a: assert property (
        take && is_or_file && to_file
        |=> file_we_o && file_wdata_o == ($past(accum_o) | $past(file_rdata_i)) && $stable(accum_o))
        else $error("or to file wrong");

    zero_flag_a: assert property (
        take && (is_or_lit || ((is_inc_file || is_or_file) && !to_file))
        |=> zero_flag_o == (accum_o == 8'h00))
        else $error("zero flag does not match result");

    zero_file_a: assert property (
        take && (is_inc_file || is_or_file) && to_file
        |=> file_we_o && zero_flag_o == (file_wdata_o == 8'h00))
        else $error("zero flag does not match file result");

    file_addr_a: assert property (
        take && (is_inc_file || is_or_file || is_inc_skip)
        |=> file_addr_o == $past(instr_word_i[6:0]))
        else $error("file address not captured");

endmodule : ibx_exec

// >>> dv/ibx_file_model.sv
// behavioural file register array facing the execution slice
// assumes a combinational read at the instruction address and a write on the clock edge
`timescale 1ns/10ps
module ibx_file_model (
    input wire logic sys_clk_i,
    input wire logic [6:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    input wire logic we_i,
    input wire logic [6:0] wr_addr_i,
    input wire logic [7:0] wr_data_i
);
    // ------------------------------------------------------------
    // storage, preloaded by the bench
    // ------------------------------------------------------------
    logic [7:0] mem_q [0:127];

    assign rd_data_o = mem_q[rd_addr_i];

    always @(posedge sys_clk_i) begin
        if (we_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end
endmodule : ibx_file_model

// >>> dv/tb.sv
// self-checking bench for the execution slice
// assumes ibx_exec and ibx_file_model; inputs change on the falling edge
`timescale 1ns/10ps
module tb;
    logic sys_clk_i, sys_rst_i, valid, we;
    logic [13:0] word;
    logic [7:0] rdata, latch, wdata, acc;
    logic [6:0] faddr;
    logic zf, idle;
    logic [12:0] pc;
    int n_errors = 0;
    int total_checks = 0;

    ibx_exec dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(valid),
        .instr_word_i(word), .file_rdata_i(rdata), .upper_address_latch_i(latch),
        .file_addr_o(faddr), .file_we_o(we), .file_wdata_o(wdata), .accum_o(acc),
        .zero_flag_o(zf), .program_counter_o(pc), .idle_slot_o(idle));
    ibx_file_model u_regs (.sys_clk_i(sys_clk_i), .rd_addr_i(word[6:0]), .rd_data_o(rdata),
        .we_i(we), .wr_addr_i(faddr), .wr_data_i(wdata));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic st(input logic [7:0] a, input logic z, input logic [12:0] p, input logic w, input logic i);
        chk(acc, a);
        chk(zf, z);
        chk(pc, p);
        chk(we, w);
        chk(idle, i);
    endtask : st

    // offer one word; valid stays up so back-to-back words need no gap
    task automatic issue(input logic [13:0] w);
        valid = 1'b1;
        word = w;
        @(negedge sys_clk_i);
    endtask : issue

    task automatic poke(input logic [6:0] a, input logic [7:0] v);
        u_regs.mem_q[a] = v;
    endtask : poke

    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_or_lit();
        issue(14'h3800);
        st(8'h00, 1'b1, 13'h0001, 1'b0, 1'b0);
        issue(14'h385a);
        st(8'h5a, 1'b0, 13'h0002, 1'b0, 1'b0);
    endtask : t_or_lit

    task automatic t_inc();
        poke(7'h11, 8'hff);
        poke(7'h7f, 8'h41);
        issue(14'h0a11);
        st(8'h00, 1'b1, 13'h0003, 1'b0, 1'b0);
        issue(14'h0aff);
        st(8'h00, 1'b0, 13'h0004, 1'b1, 1'b0);
        chk({faddr, 1'b0, wdata}, {7'h7f, 1'b0, 8'h42});
    endtask : t_inc

    task automatic t_or_file();
        poke(7'h22, 8'h30);
        issue(14'h04a2);
        st(8'h00, 1'b0, 13'h0005, 1'b1, 1'b0);
        chk({faddr, 1'b0, wdata}, {7'h22, 1'b0, 8'h30});
        issue(14'h3803);
        issue(14'h0422);
        st(8'h33, 1'b0, 13'h0007, 1'b0, 1'b0);
    endtask : t_or_file

    task automatic t_skip();
        poke(7'h05, 8'h05);
        poke(7'h06, 8'hff);
        issue(14'h0a11);
        issue(14'h0f85);
        st(8'h00, 1'b1, 13'h0009, 1'b1, 1'b0);
        chk(wdata, 8'h06);
        issue(14'h3801);
        issue(14'h0f06);
        st(8'h00, 1'b0, 13'h000c, 1'b0, 1'b1);
        issue(14'h38ff);
        st(8'h00, 1'b0, 13'h000c, 1'b0, 1'b0);
        chk(u_regs.mem_q[7'h05], 8'h06);
        // wrap to zero written back to the file in the same cycle as the idle slot
        poke(7'h07, 8'hff);
        issue(14'h0f87);
        st(8'h00, 1'b0, 13'h000e, 1'b1, 1'b1);
        chk({faddr, 1'b0, wdata}, {7'h07, 1'b0, 8'h00});
        issue(14'h38ff);
        st(8'h00, 1'b0, 13'h000e, 1'b0, 1'b0);
        chk(u_regs.mem_q[7'h07], 8'h00);
    endtask : t_skip

    task automatic t_jump();
        latch = 8'h18;
        issue(14'h2fff);
        st(8'h00, 1'b0, 13'h1fff, 1'b0, 1'b1);
        issue(14'h38ff);
        st(8'h00, 1'b0, 13'h1fff, 1'b0, 1'b0);
        latch = 8'he7;
        issue(14'h2923);
        st(8'h00, 1'b0, 13'h0123, 1'b0, 1'b1);
        valid = 1'b0;
        @(negedge sys_clk_i);
        latch = 8'h08;
        issue(14'h2800);
        st(8'h00, 1'b0, 13'h0800, 1'b0, 1'b1);
        valid = 1'b0;
        @(negedge sys_clk_i);
    endtask : t_jump

    // ------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        sys_rst_i = 1'b1;
        valid = 1'b0;
        word = 14'h0000;
        latch = 8'h00;
        repeat (4) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        st(8'h00, 1'b0, 13'h0000, 1'b0, 1'b0);
        t_or_lit();
        t_inc();
        t_or_file();
        t_skip();
        t_jump();
        results();
    end

    initial begin
        #20000;
        n_errors++;
        results();
    end
endmodule : tb
